// ==== design/aims_pkg.sv ====
/*
 * constants and encodings for the analog input multiplexer control.
 * assumes one 50 MHz system clock and an active-low asynchronous reset around it.
 */
`default_nettype none

package aims_pkg;

   // register addresses on the special function register bus
   localparam logic [7:0] AIMS_ADDR_PAIR_CFG = 8'hba;
   localparam logic [7:0] AIMS_ADDR_CHAN_SEL = 8'hbb;

   // reset values
   localparam logic [3:0] AIMS_PAIR_RESET = 4'h0;
   localparam logic [3:0] AIMS_CHAN_RESET = 4'h0;
   localparam logic [2:0] AIMS_GAIN_RESET = 3'h0;
   localparam logic [7:0] AIMS_SINGLE_RESET = 8'h01; // input 0 single-ended
   localparam logic [5:0] AIMS_GAIN_SEL_RESET = 6'h01; // unity gain

   // field positions
   localparam int unsigned AIMS_FIELD_LSB = 0;
   localparam int unsigned AIMS_FIELD_MSB = 3;
   localparam int unsigned AIMS_TEMP_BIT = 3;

   // widths of the selection outputs
   localparam int unsigned AIMS_NUM_INPUTS = 8;
   localparam int unsigned AIMS_NUM_PAIRS = 4;
   localparam int unsigned AIMS_NUM_GAINS = 6;

   // one-hot gain output positions
   localparam int unsigned AIMS_GAIN_X1 = 0;
   localparam int unsigned AIMS_GAIN_X2 = 1;
   localparam int unsigned AIMS_GAIN_X4 = 2;
   localparam int unsigned AIMS_GAIN_X8 = 3;
   localparam int unsigned AIMS_GAIN_X16 = 4;
   localparam int unsigned AIMS_GAIN_HALF = 5;

   // timing
   localparam int unsigned AIMS_CLK_MHZ = 50;
   localparam int unsigned AIMS_SETTLE_NS = 1500;
   localparam int unsigned AIMS_SETTLE_CYC = (AIMS_SETTLE_NS * AIMS_CLK_MHZ + 999) / 1000;
   localparam logic [6:0] AIMS_SETTLE_LOAD = 7'(AIMS_SETTLE_CYC);
   localparam int unsigned AIMS_TRACK_SAR_CLKS = 3;
   localparam logic [1:0] AIMS_TRACK_LAST = 2'(AIMS_TRACK_SAR_CLKS - 1);

   // conversion sequencer states, one-hot
   typedef enum logic [2:0] {
      AIMS_ST_IDLE = 3'b001,
      AIMS_ST_TRACK = 3'b010,
      AIMS_ST_CONV = 3'b100
   } aims_state_type;

endpackage : aims_pkg

`default_nettype wire

// ==== design/aims_track_timer.sv ====
/*
 * track-and-hold sequencer: turns a start request into a tracking interval
 * (low-power mode) and a successive-approximation start pulse.
 * assumes sar_tick is a one-cycle pulse per converter clock on the same clock.
 */
`default_nettype none

module aims_track_timer
   import aims_pkg::*;
(
   input wire logic clk,
   input wire logic nrst,
   input wire logic low_power, // tracking mode bit
   input wire logic conv_start, // start request pulse
   input wire logic sar_tick, // one pulse per sar clock
   input wire logic conv_done, // converter finished
   output logic sar_go, // pulse: begin approximation steps
   output logic tracking, // input is being tracked
   output logic converting // conversion in progress
);

   aims_state_type state_q; // sequencer state
   aims_state_type state_d;
   logic [1:0] cnt_q; // sar clocks tracked so far
   logic [1:0] cnt_d;
   logic go_d;
   logic track_d;

   // next state
   always_comb begin
      state_d = state_q;
      cnt_d = cnt_q;
      go_d = 1'b0;
      case (state_q)
         AIMS_ST_IDLE: begin
            if (conv_start) begin
               cnt_d = 2'h0;
               if (low_power) begin
                  state_d = AIMS_ST_TRACK;
               end else begin
                  state_d = AIMS_ST_CONV;
                  go_d = 1'b1;
               end
            end
         end
         AIMS_ST_TRACK: begin
            if (sar_tick) begin
               if (cnt_q == AIMS_TRACK_LAST) begin
                  state_d = AIMS_ST_CONV;
                  go_d = 1'b1;
               end else begin
                  cnt_d = cnt_q + 2'h1;
               end
            end
         end
         AIMS_ST_CONV: begin
            // back to idle when result is in
            if (conv_done) begin
               state_d = AIMS_ST_IDLE;
            end
         end
         default: begin
            state_d = AIMS_ST_IDLE;
         end
      endcase
   end

   assign track_d = low_power ? (state_d == AIMS_ST_TRACK) : (state_d == AIMS_ST_IDLE);

   // state and output flops
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         state_q <= AIMS_ST_IDLE;
         cnt_q <= 2'h0;
         sar_go <= 1'b0;
         tracking <= 1'b0;
         converting <= 1'b0;
      end else begin
         state_q <= state_d;
         cnt_q <= cnt_d;
         sar_go <= go_d;
         tracking <= track_d;
         converting <= (state_d == AIMS_ST_CONV);
      end
   end

endmodule : aims_track_timer

`default_nettype wire

// ==== design/aims_mux_ctrl.sv ====
/*
 * multiplexer control: the two byte-wide selection registers on the
 * special function register bus, the input/pair/temperature decode, the
 * gain decode, a settling-time status and the track-and-hold sequencer.
 * assumes bus strobes, gain and track bits come from logic on clk.
 */
`default_nettype none

module aims_mux_ctrl
   import aims_pkg::*;
(
   input wire logic clk,
   input wire logic nrst,
   input wire logic [7:0] sfr_addr, // register address
   input wire logic [7:0] sfr_wdata, // write data
   input wire logic sfr_wr, // write strobe, one cycle
   input wire logic sfr_rd, // read strobe, one cycle
   output logic [7:0] sfr_rdata, // read data, cycle after sfr_rd
   input wire logic [2:0] gain_field, // amplifier gain code
   input wire logic low_power_track_sel, // tracking mode bit
   input wire logic conv_start, // start of conversion pulse
   input wire logic sar_tick, // sar clock pulse
   input wire logic conv_done, // conversion complete pulse
   output logic [7:0] sel_single, // single-ended input enables
   output logic [3:0] sel_diff, // differential pair enables
   output logic sel_temp, // temperature sensor enable
   output logic sel_undefined, // odd code inside a pair
   output logic [5:0] gain_sel, // one-hot amplifier gain
   output logic settle_busy, // settling interval running
   output logic sar_go, // begin approximation steps
   output logic tracking, // input is being tracked
   output logic converting // conversion in progress
);

   // the registers hold only what software wrote; the selection outputs are
   // decoded again on every edge, so a write shows on the analog switches at
   // the very edge that takes it and the settling interval starts there too.
   // the gain code, track bit and conversion strobes live in other registers
   // and arrive here as plain levels and pulses on the same clock.

   // decode channel code and pair bits into {undef, temp, diff, single}
   // result layout: [13] undef, [12] temp, [11:8] diff, [7:0] single
   // pair k joins input 2k (positive) and input 2k+1 (negative)
   function automatic logic [13:0] aims_decode(input logic [3:0] pair, input logic [3:0] code);
      logic [7:0] single;
      logic [3:0] diff;
      logic temp;
      logic undef;
      int unsigned n;
      single = 8'h00;
      diff = 4'h0;
      temp = 1'b0;
      undef = 1'b0;
      // input number in the external bank; its pair index is n / 2
      n = 32'(code[2:0]);
      if (code[AIMS_TEMP_BIT]) begin
         temp = 1'b1;
      // pair bit clear routes single input
      end else if (!pair[n / 2]) begin
         single[n] = 1'b1;
      end else if ((n % 2) == 0) begin
         diff[n / 2] = 1'b1;
      // odd code in a pair selects nothing
      end else begin
         undef = 1'b1;
      end
      // at most one group is set, so the switches never short two inputs
      return {undef, temp, diff, single};
   endfunction : aims_decode

   // map gain code to one-hot gain
   // codes 10x and 11x ignore their lowest bit
   function automatic logic [5:0] aims_gain(input logic [2:0] g);
      logic [5:0] oh;
      oh = 6'h00;
      case (g)
         3'h0: oh[AIMS_GAIN_X1] = 1'b1;
         3'h1: oh[AIMS_GAIN_X2] = 1'b1;
         3'h2: oh[AIMS_GAIN_X4] = 1'b1;
         3'h3: oh[AIMS_GAIN_X8] = 1'b1;
         3'h4, 3'h5: oh[AIMS_GAIN_X16] = 1'b1;
         default: oh[AIMS_GAIN_HALF] = 1'b1;
      endcase
      return oh;
   endfunction : aims_gain

   // stored register fields and their next values
   logic [3:0] pair_q; // pair configuration bits
   logic [3:0] pair_d;
   logic [3:0] chan_q; // channel code
   logic [3:0] chan_d;
   logic [2:0] gain_q; // last gain seen
   logic [6:0] settle_q; // settling countdown
   logic [6:0] settle_d;
   logic [7:0] rdata_d;

   // address decode
   // addresses outside the two registers neither store nor read back
   wire hit_pair = (sfr_addr == AIMS_ADDR_PAIR_CFG);
   wire hit_chan = (sfr_addr == AIMS_ADDR_CHAN_SEL);
   wire wr_pair = sfr_wr && hit_pair;
   wire wr_chan = sfr_wr && hit_chan;

   // only the low nibble is stored
   assign pair_d = wr_pair ? sfr_wdata[AIMS_FIELD_MSB:AIMS_FIELD_LSB] : pair_q;
   // only the low nibble is stored
   assign chan_d = wr_chan ? sfr_wdata[AIMS_FIELD_MSB:AIMS_FIELD_LSB] : chan_q;

   // decoded selection from the values being written, so a write takes
   // effect on the edge that stores it rather than one cycle later
   wire [13:0] sel_next = aims_decode(pair_d, chan_d);
   // named slices of the decoded selection
   wire [7:0] single_next = sel_next[7:0]; // one enable per input pin
   wire [3:0] diff_next = sel_next[11:8]; // one enable per pair
   wire temp_next = sel_next[12]; // temperature sensor
   wire undef_next = sel_next[13]; // odd code inside a pair
   // one-hot gain from the live gain code
   wire [5:0] gain_next = aims_gain(gain_field);

   // any change of mux or gain restarts settling; rewriting the same value
   // leaves the analog path untouched, so it does not restart the count
   // register change: next value against stored value
   wire mux_change = (pair_d != pair_q) || (chan_d != chan_q);
   // gain change: live code against last code seen
   wire gain_change = (gain_field != gain_q);

   // settling countdown of 1.5 us
   // the load is 1.5 us of system clocks, rounded up; the count rests at
   // zero until a fresh change reloads it. the status is advisory only:
   // conversions are never held off, software must watch it
   assign settle_d = (mux_change || gain_change) ? AIMS_SETTLE_LOAD :
                     (settle_q != 7'h00) ? settle_q - 7'h01 : 7'h00;

   // upper nibbles read as zero; unmapped reads zero
   assign rdata_d = !sfr_rd ? 8'h00 :
                    hit_pair ? {4'h0, pair_q} :
                    hit_chan ? {4'h0, chan_q} : 8'h00;

   // register storage
   // upper nibbles are never stored, so they cannot leak into the decode
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         pair_q <= AIMS_PAIR_RESET;
         chan_q <= AIMS_CHAN_RESET;
      end else begin
         pair_q <= pair_d;
         chan_q <= chan_d;
      end
   end

   // analog selection controls
   // reset value matches the decode of the cleared registers
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         sel_single <= AIMS_SINGLE_RESET;
         sel_diff <= 4'h0;
         sel_temp <= 1'b0;
         sel_undefined <= 1'b0;
      end else begin
         sel_single <= single_next;
         sel_diff <= diff_next;
         sel_temp <= temp_next;
         sel_undefined <= undef_next;
      end
   end

   // gain tracking and decode
   // gain_q remembers the last code so that a change restarts settling
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         gain_q <= AIMS_GAIN_RESET;
         gain_sel <= AIMS_GAIN_SEL_RESET;
      end else begin
         gain_q <= gain_field;
         gain_sel <= gain_next;
      end
   end

   // settling status
   // busy mirrors the next count so it rises on the changing edge
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         settle_q <= 7'h00;
         settle_busy <= 1'b0;
      end else begin
         settle_q <= settle_d;
         settle_busy <= (settle_d != 7'h00);
      end
   end

   // read data
   // stands for one cycle after the strobe, zero otherwise; a read in the
   // same cycle as a write returns the old value
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         sfr_rdata <= 8'h00;
      end else begin
         sfr_rdata <= rdata_d;
      end
   end

   // track-and-hold sequencer
   // it owns the track/convert timing; this block only hands it the mode
   // bit and strobes and passes its registered outputs to the ports
   aims_track_timer u_track (
      .clk(clk),
      .nrst(nrst),
      .low_power(low_power_track_sel),
      .conv_start(conv_start),
      .sar_tick(sar_tick),
      .conv_done(conv_done),
      .sar_go(sar_go),
      .tracking(tracking),
      .converting(converting)
   );

endmodule : aims_mux_ctrl

`default_nettype wire

// ==== verif/aims_mux_sva.sv ====
/* port checker for aims_mux_ctrl.
   assumes it is bound to the top module, one clock domain. */
`default_nettype none
module aims_mux_sva
   import aims_pkg::*;
(
   input wire logic clk,
   input wire logic nrst,
   input wire logic [7:0] sfr_addr,
   input wire logic [7:0] sfr_wdata,
   input wire logic sfr_wr,
   input wire logic sfr_rd,
   input wire logic [7:0] sfr_rdata,
   input wire logic [2:0] gain_field,
   input wire logic low_power_track_sel,
   input wire logic conv_start,
   input wire logic sar_tick,
   input wire logic conv_done,
   input wire logic [7:0] sel_single,
   input wire logic [3:0] sel_diff,
   input wire logic sel_temp,
   input wire logic sel_undefined,
   input wire logic [5:0] gain_sel,
   input wire logic settle_busy,
   input wire logic sar_go,
   input wire logic tracking,
   input wire logic converting
);
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   logic [3:0] tk_q; // sar clocks since last start
   logic [3:0] pair_seen_q; // pair bits as last written
   logic [3:0] chan_seen_q; // channel code as last written
   wire wr_code = sfr_wr && sfr_addr == AIMS_ADDR_CHAN_SEL; // channel code write
   // clear on start, count sar clocks
   always_ff @(posedge clk or negedge nrst)
      if (!nrst) tk_q <= 4'h0;
      else if (conv_start) tk_q <= 4'h0;
      else if (sar_tick) tk_q <= tk_q + 4'h1;
   // shadow of the two registers, low nibbles only
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         pair_seen_q <= 4'h0;
         chan_seen_q <= 4'h0;
      end else if (sfr_wr) begin
         if (sfr_addr == AIMS_ADDR_PAIR_CFG) pair_seen_q <= sfr_wdata[3:0];
         if (sfr_addr == AIMS_ADDR_CHAN_SEL) chan_seen_q <= sfr_wdata[3:0];
      end
   end
   a_rd_upper_zero: assert property (sfr_rd |=> sfr_rdata[7:4] == 4'h0)
      else $error("upper nibble read nonzero");
   a_temp_pick: assert property (wr_code && sfr_wdata[3]
      |=> sel_temp && sel_single == 8'h00) else $error("temp sensor not picked");
   a_single_pick: assert property (wr_code && !sfr_wdata[3]
      && !pair_seen_q[sfr_wdata[2:1]]
      |=> sel_single == (8'h01 << $past(sfr_wdata[2:0])) && sel_diff == 4'h0
      && !sel_undefined) else $error("input not routed");
   a_pair_pick: assert property (wr_code && !sfr_wdata[3] && !sfr_wdata[0]
      && pair_seen_q[sfr_wdata[2:1]]
      |=> sel_diff == (4'h1 << $past(sfr_wdata[2:1])) && sel_single == 8'h00
      && !sel_undefined) else $error("pair not routed");
   a_odd_undef: assert property (wr_code && !sfr_wdata[3] && sfr_wdata[0]
      && pair_seen_q[sfr_wdata[2:1]]
      |=> sel_undefined && sel_single == 8'h00 && sel_diff == 4'h0)
      else $error("odd pair code routed");
   a_gain_x16: assert property (gain_field[2:1] == 2'b10 |=> gain_sel == 6'h10)
      else $error("gain 16 wrong");
   a_gain_half: assert property (gain_field[2:1] == 2'b11 |=> gain_sel == 6'h20)
      else $error("gain half wrong");
   a_settle_gain: assert property (gain_field != $past(gain_field) |=> settle_busy)
      else $error("settle not started");
   a_settle_mux: assert property (
      wr_code && sfr_wdata[3:0] != chan_seen_q |=> settle_busy)
      else $error("settle not started on write");
   a_track_three: assert property (sar_go && low_power_track_sel |-> tk_q == 4'h3)
      else $error("tracking not three sar clocks");
   a_go_pulse: assert property (sar_go |=> !sar_go)
      else $error("start pulse too long");
   a_idle_track: assert property (
      (nrst && !low_power_track_sel && !converting && !conv_start)[*2] |-> tracking)
      else $error("idle input not tracked");
   c_temp: cover property (sel_temp);
   c_odd: cover property (sel_undefined);
   c_lp_go: cover property (sar_go && low_power_track_sel);
   c_settle_end: cover property ($fell(settle_busy));
endmodule : aims_mux_sva
bind aims_mux_ctrl aims_mux_sva u_sva (
   .clk(clk),
   .nrst(nrst),
   .sfr_addr(sfr_addr),
   .sfr_wdata(sfr_wdata),
   .sfr_wr(sfr_wr),
   .sfr_rd(sfr_rd),
   .sfr_rdata(sfr_rdata),
   .gain_field(gain_field),
   .low_power_track_sel(low_power_track_sel),
   .conv_start(conv_start),
   .sar_tick(sar_tick),
   .conv_done(conv_done),
   .sel_single(sel_single),
   .sel_diff(sel_diff),
   .sel_temp(sel_temp),
   .sel_undefined(sel_undefined),
   .gain_sel(gain_sel),
   .settle_busy(settle_busy),
   .sar_go(sar_go),
   .tracking(tracking),
   .converting(converting)
);
`default_nettype wire

// ==== verif/testbench.sv ====
/* self-checking bench for aims_mux_ctrl against an integer model.
   assumes the package and design are compiled first. */
`default_nettype none
module testbench import aims_pkg::*;;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 0, nrst = 0, sfr_wr = 0, sfr_rd = 0, low_power_track_sel = 0;
   logic conv_start = 0, sar_tick = 0, conv_done = 0;
   logic [7:0] sfr_addr = 0, sfr_wdata = 0, sfr_rdata, sel_single;
   logic [2:0] gain_field = 0;
   logic [3:0] sel_diff;
   logic [5:0] gain_sel;
   logic sel_temp, sel_undefined, settle_busy, sar_go, tracking, converting;
   int n_mismatch = 0, checks_done = 0, seed = 32'h08c3, pc = 0, cs = 0, n;
   logic [5:0] exp_gain; // model gain one-hot
   wire [13:0] sel_all = {sel_single, sel_diff, sel_temp, sel_undefined}; // packed selection
   aims_mux_ctrl DUT (
      .clk(clk),
      .nrst(nrst),
      .sfr_addr(sfr_addr),
      .sfr_wdata(sfr_wdata),
      .sfr_wr(sfr_wr),
      .sfr_rd(sfr_rd),
      .sfr_rdata(sfr_rdata),
      .gain_field(gain_field),
      .low_power_track_sel(low_power_track_sel),
      .conv_start(conv_start),
      .sar_tick(sar_tick),
      .conv_done(conv_done),
      .sel_single(sel_single),
      .sel_diff(sel_diff),
      .sel_temp(sel_temp),
      .sel_undefined(sel_undefined),
      .gain_sel(gain_sel),
      .settle_busy(settle_busy),
      .sar_go(sar_go),
      .tracking(tracking),
      .converting(converting)
   );
   // free-running system clock
   always #10 clk = ~clk;
   task chk(string what, logic [19:0] seen, logic [19:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED %s exp %h seen %h", what, exp, seen);
      end
   endtask : chk
   task test_done;
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : test_done
   // register write, model follows the low nibble
   task wr(logic [7:0] a, logic [7:0] d);
      @(posedge clk);
      sfr_addr <= a;
      sfr_wdata <= d;
      sfr_wr <= 1'b1;
      @(posedge clk);
      sfr_wr <= 1'b0;
      #1;
      if (a == AIMS_ADDR_PAIR_CFG) pc = d[3:0];
      if (a == AIMS_ADDR_CHAN_SEL) cs = d[3:0];
   endtask : wr
   task rd(logic [7:0] a, logic [7:0] e);
      @(posedge clk);
      sfr_addr <= a;
      sfr_rd <= 1'b1;
      @(posedge clk);
      sfr_rd <= 1'b0;
      #1;
      chk("rdata", sfr_rdata, e);
   endtask : rd
   // expected {single, diff, temp, undefined}
   function logic [13:0] expsel(int p, int c);
      if (c > 7) return 14'h2;
      if (p[c/2] && c % 2) return 14'h1;
      if (p[c/2]) return 14'(4 << (c/2));
      return 14'(64 << c);
   endfunction : expsel
   // main sequence
   initial begin
      repeat (6) @(posedge clk);
      nrst <= 1'b1;
      @(posedge clk);
      #1;
      chk("reset sel", sel_all, 14'h40);
      chk("idle track", tracking, 1'b1);
      rd(AIMS_ADDR_PAIR_CFG, 8'h00);
      for (int p = 0; p < 16; p++) begin
         wr(AIMS_ADDR_PAIR_CFG, {4'($random(seed)), 4'(p)});
         for (int c = 0; c < 16; c++) begin
            wr(AIMS_ADDR_CHAN_SEL, {4'($random(seed)), 4'(c)});
            chk("sel", sel_all, expsel(pc, cs));
         end
         rd(AIMS_ADDR_PAIR_CFG, 8'(pc));
         rd(AIMS_ADDR_CHAN_SEL, 8'(cs));
      end
      wr(8'hbc, 8'hff);
      rd(8'hbc, 8'h00);
      for (int g = 1; g < 9; g++) begin
         @(posedge clk);
         gain_field <= 3'(g);
         @(posedge clk);
         #1;
         n = 0;
         exp_gain = g % 8 < 4 ? 6'(1 << g % 8) : (g % 8 < 6 ? 6'h10 : 6'h20);
         chk("gain", gain_sel, exp_gain);
         while (settle_busy === 1'b1 && n < 200) begin
            n++;
            @(posedge clk);
            #1;
         end
         chk("settle", n, 75);
      end
      @(posedge clk);
      low_power_track_sel <= 1'b1;
      conv_start <= 1'b1;
      @(posedge clk);
      conv_start <= 1'b0;
      sar_tick <= 1'b1;
      #1;
      chk("lp track", tracking, 1'b1);
      repeat (2) @(posedge clk);
      #1;
      chk("early go", sar_go, 1'b0);
      @(posedge clk);
      sar_tick <= 1'b0;
      #1;
      chk("lp go", {sar_go, converting}, 2'b11);
      @(posedge clk);
      conv_done <= 1'b1;
      @(posedge clk);
      conv_done <= 1'b0;
      low_power_track_sel <= 1'b0;
      conv_start <= 1'b1;
      #1;
      chk("done", converting, 1'b0);
      @(posedge clk);
      conv_start <= 1'b0;
      #1;
      chk("go", sar_go, 1'b1);
      @(posedge clk);
      nrst <= 1'b0;
      repeat (2) @(posedge clk);
      nrst <= 1'b1;
      rd(AIMS_ADDR_CHAN_SEL, 8'h00);
      chk("reset again", sel_all, 14'h40);
      test_done;
   end
   // hang guard
   initial begin
      #400000;
      n_mismatch++;
      test_done;
   end
endmodule : testbench
`default_nettype wire
